// *** card_host_control_signals_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module card_host_control_signals_tb;
  import chc_pkg::*;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0;
  logic ide_n = 1'b1, io_m = 1'b0, crst = 1'b1, srst = 1'b0, attr_n = 1'b1, wr_n = 1'b1;
  logic stop = 1'b0, hrdy_n = 1'b1, busy = 1'b0, req = 1'b0, dir_in = 1'b0, can_acc = 1'b0;
  logic word_ok = 1'b0, wide = 1'b0, wxfer = 1'b0, rogue = 1'b0, out_burst = 1'b0;
  logic ack_n, hstb, in_rst, rdy, wait_n, dreq, cdr_n, cstb, cstb_q, wp_n, cwr, awr, latch, bend;
  chc_mode_t mode;
  logic [15:0] n_cwr = '0, n_awr = '0, n_lat = '0, n_end = '0, n_tgl = '0, c0;
  int bad_count = 0, comparisons = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  chc_host_ctrl uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ide_mode_sel_n_i(ide_n),
    .io_mode_i(io_m), .card_reset_i(crst), .soft_reset_i(srst), .attr_sel_n_i(attr_n),
    .write_strobe_n_i(wr_n), .dma_ack_n_i(ack_n), .stop_i(stop), .host_data_strobe_i(hstb),
    .host_dma_ready_n_i(hrdy_n), .core_busy_i(busy), .core_dma_req_i(req),
    .core_dma_dir_in_i(dir_in), .core_can_accept_i(can_acc), .core_word_ok_i(word_ok),
    .core_wide_port_i(wide), .core_word_xfer_i(wxfer), .card_in_reset_o(in_rst),
    .ready_o(rdy), .wait_n_o(wait_n), .dma_request_o(dreq), .card_dma_ready_n_o(cdr_n),
    .card_data_strobe_o(cstb), .wp_port_is_wide_n_o(wp_n), .common_wr_o(cwr),
    .attr_wr_o(awr), .host_data_latch_o(latch), .burst_end_o(bend), .mode_o(mode));

  chc_host_model host (.clk_sys_i(clk_sys_i), .dma_request_i(dreq), .rogue_ack_i(rogue),
    .out_burst_i(out_burst), .dma_ack_n_o(ack_n), .host_data_strobe_o(hstb));

  // pulse and toggle tallies, compared as differences by the scenarios
  always @(posedge clk_sys_i) begin
    cstb_q <= cstb;
    if (cwr === 1'b1) n_cwr++;
    if (awr === 1'b1) n_awr++;
    if (latch === 1'b1) n_lat++;
    if (bend === 1'b1) n_end++;
    if (cstb !== cstb_q) n_tgl++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wait_ready;
    for (int i = 0; i < 400 && rdy !== 1'b1; i++) cyc(1);
    chk(rdy, 1'b1);
  endtask
  // strobe held 4 clocks each way, well above the 2-clock minimum
  task automatic host_write(input logic a);
    attr_n = a;
    wr_n = 1'b0;
    cyc(4);
    wr_n = 1'b1;
    cyc(4);
    attr_n = 1'b1;
    cyc(4);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_power_up;  // reset pin stuck high since power-on
    wait_ready();
    chk(in_rst, 1'b0);
    chk(wp_n, 1'b0);
    chk(mode, CHC_MODE_MEM);
    busy = 1'b1;
    cyc(3);
    chk(wait_n, 1'b0);
    chk(rdy, 1'b0);
    busy = 1'b0;
    cyc(3);
    chk(wait_n, 1'b1);
    chk(rdy, 1'b1);
  endtask
  task automatic t_mem_write;
    c0 = n_cwr + n_awr;
    host_write(1'b1);
    chk(n_cwr - (c0 - n_awr), 16'h0001);
    host_write(1'b0);
    chk(n_awr + n_cwr - c0, 16'h0002);
  endtask
  task automatic t_pc_reset;
    crst = 1'b0;
    cyc(8);
    crst = 1'b1;
    cyc(6);
    chk(in_rst, 1'b1);
    crst = 1'b0;
    wait_ready();
    srst = 1'b1;
    cyc(6);
    chk(in_rst, 1'b1);
    srst = 1'b0;
    wait_ready();
  endtask
  task automatic t_io_mode;
    io_m = 1'b1;
    wide = 1'b1;
    cyc(8);
    chk(mode, CHC_MODE_IO);
    chk(wp_n, 1'b0);
    wide = 1'b0;
    cyc(6);
    chk(wp_n, 1'b1);
    c0 = n_awr;
    host_write(1'b0);
    chk(n_awr - c0, 16'h0001);
    c0 = n_cwr;
    host_write(1'b1);
    chk(n_cwr - c0, 16'h0000);
  endtask
  task automatic t_ide;
    io_m = 1'b0;
    ide_n = 1'b0;
    crst = 1'b1;
    cyc(8);
    wait_ready();
    chk(mode, CHC_MODE_IDE);
    wxfer = 1'b1;
    word_ok = 1'b1;
    cyc(6);
    chk(wp_n, 1'b0);
    chk(wait_n, 1'b1);
    wxfer = 1'b0;
    word_ok = 1'b0;
    cyc(6);
    chk(wp_n, 1'b1);
    chk(wait_n, 1'b0);
    c0 = n_cwr + n_awr;
    host_write(1'b0);
    host_write(1'b1);
    chk(n_cwr + n_awr - c0, 16'h0000);
    crst = 1'b0;
    cyc(6);
    chk(in_rst, 1'b1);
    crst = 1'b1;
    wait_ready();
  endtask
  task automatic t_udma;
    can_acc = 1'b1;
    rogue = 1'b1;
    cyc(12);
    chk(cdr_n, 1'b1);
    chk(dreq, 1'b0);
    rogue = 1'b0;
    cyc(4);
    dir_in = 1'b1;
    hrdy_n = 1'b0;
    req = 1'b1;
    cyc(12);
    chk(dreq, 1'b1);
    c0 = n_tgl;
    cyc(10);
    chk(n_tgl - c0, 16'h000A);
    hrdy_n = 1'b1;
    cyc(6);
    c0 = n_tgl;
    cyc(10);
    chk(n_tgl - c0, 16'h0000);
    c0 = n_end;
    stop = 1'b1;
    cyc(8);
    chk(n_end - c0, 16'h0001);
    stop = 1'b0;
    req = 1'b0;
    cyc(10);
    dir_in = 1'b0;
    req = 1'b1;
    cyc(12);
    chk(cdr_n, 1'b0);
    can_acc = 1'b0;
    cyc(3);
    chk(cdr_n, 1'b1);
    can_acc = 1'b1;
    c0 = n_lat;
    out_burst = 1'b1;
    cyc(100);
    out_burst = 1'b0;
    cyc(8);
    chk(n_lat - c0, 16'h0010);
    stop = 1'b1;
    cyc(8);
    stop = 1'b0;
    req = 1'b0;
    cyc(8);
  endtask

  initial begin
    cyc(10);
    rst_n_i = 1'b1;
    t_power_up();
    t_mem_write();
    t_pc_reset();
    t_io_mode();
    t_ide();
    t_udma();
    end_of_test();
  end
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end
endmodule // card_host_control_signals_tb
`default_nettype wire

// *** chc_host_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "chc_regs.svh"
module chc_host_ctrl (
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  wire logic                ide_mode_sel_n_i,
  input  wire logic                io_mode_i,
  input  wire logic                card_reset_i,
  input  wire logic                soft_reset_i,
  input  wire logic                attr_sel_n_i,
  input  wire logic                write_strobe_n_i,
  input  wire logic                dma_ack_n_i,
  input  wire logic                stop_i,
  input  wire logic                host_data_strobe_i,
  input  wire logic                host_dma_ready_n_i,
  input  wire logic                core_busy_i,
  input  wire logic                core_dma_req_i,
  input  wire logic                core_dma_dir_in_i,
  input  wire logic                core_can_accept_i,
  input  wire logic                core_word_ok_i,
  input  wire logic                core_wide_port_i,
  input  wire logic                core_word_xfer_i,
  output var  logic                card_in_reset_o,
  output var  logic                ready_o,
  output var  logic                wait_n_o,
  output var  logic                dma_request_o,
  output var  logic                card_dma_ready_n_o,
  output var  logic                card_data_strobe_o,
  output var  logic                wp_port_is_wide_n_o,
  output var  logic                common_wr_o,
  output var  logic                attr_wr_o,
  output var  logic                host_data_latch_o,
  output var  logic                burst_end_o,
  output var  chc_pkg::chc_mode_t  mode_o
);
  import chc_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  logic [9:0] pin_s;
  chc_sync #(.W(10), .RST_VAL(`CHC_PIN_IDLE)) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_q),
    .d_i       ({ide_mode_sel_n_i, io_mode_i, card_reset_i, attr_sel_n_i,
                 write_strobe_n_i, dma_ack_n_i, stop_i, host_data_strobe_i,
                 host_dma_ready_n_i, soft_reset_i}),
    .q_o       (pin_s)
  );
  logic ide_sel_n_s, io_s, rst_pin_s, attr_n_s, we_n_s;
  logic ack_n_s, stop_s, hstb_s, hrdy_n_s, soft_s;
  assign {ide_sel_n_s, io_s, rst_pin_s, attr_n_s, we_n_s,
          ack_n_s, stop_s, hstb_s, hrdy_n_s, soft_s} = pin_s;

  // ----------------------------------------------------------------
  // mode and reset
  // ----------------------------------------------------------------
  chc_mode_t mode_d;
  always_comb begin
    if (!ide_sel_n_s)     mode_d = CHC_MODE_IDE;
    else if (io_s)        mode_d = CHC_MODE_IO;
    else                  mode_d = CHC_MODE_MEM;
  end
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) mode_o <= CHC_MODE_MEM;
    else        mode_o <= mode_d;
  end

  // outside ide mode the reset pin only becomes level sensitive once seen low,
  // so a stuck high input yields just the initial reset
  logic armed_q;
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q)          armed_q <= 1'b0;
    else if (!rst_pin_s) armed_q <= 1'b1;
  end

  logic ext_rst;
  always_comb begin
    if (mode_d == CHC_MODE_IDE) ext_rst = !rst_pin_s;
    else ext_rst = (rst_pin_s && armed_q) || soft_s;
  end

  logic [`CHC_CNT_W-1:0] rcnt_q;
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      rcnt_q          <= `CHC_INIT_RST_CYC;
      card_in_reset_o <= 1'b1;
    end else if (ext_rst) begin
      rcnt_q          <= `CHC_INIT_RST_CYC;
      card_in_reset_o <= 1'b1;
    end else if (rcnt_q != '0) begin
      rcnt_q          <= rcnt_q - 1'b1;
      card_in_reset_o <= 1'b1;
    end else begin
      card_in_reset_o <= 1'b0;
    end
  end

  logic [`CHC_CNT_W-1:0] bcnt_q;
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      bcnt_q  <= `CHC_BUSY_CYC;
      ready_o <= 1'b0;
    end else if (card_in_reset_o) begin
      bcnt_q  <= `CHC_BUSY_CYC;
      ready_o <= 1'b0;
    end else if (bcnt_q != '0) begin
      bcnt_q  <= bcnt_q - 1'b1;
      ready_o <= 1'b0;
    end else begin
      ready_o <= !core_busy_i;
    end
  end
  logic init_done;
  assign init_done = !card_in_reset_o && (bcnt_q == '0);

  // ----------------------------------------------------------------
  // ultra dma burst control
  // ----------------------------------------------------------------
  chc_udma_t udma_q;
  logic      hstb_q;
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      udma_q      <= CHC_UDMA_IDLE;
      burst_end_o <= 1'b0;
    end else begin
      burst_end_o <= 1'b0;
      if (card_in_reset_o || mode_o != CHC_MODE_IDE) begin
        udma_q <= CHC_UDMA_IDLE;
      end else begin
        unique case (udma_q)
          CHC_UDMA_IDLE: begin
            // ack only counts while a request is out
            if (dma_request_o && !ack_n_s && !stop_s) begin
              udma_q <= core_dma_dir_in_i ? CHC_UDMA_IN : CHC_UDMA_OUT;
            end
          end
          CHC_UDMA_IN, CHC_UDMA_OUT: begin
            if (stop_s || ack_n_s) begin
              udma_q      <= CHC_UDMA_IDLE;
              burst_end_o <= 1'b1;
            end
          end
        endcase
      end
    end
  end
  logic burst;
  assign burst = (udma_q != CHC_UDMA_IDLE);

  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) dma_request_o <= 1'b0;
    else        dma_request_o <= core_dma_req_i && init_done && (mode_o == CHC_MODE_IDE);
  end

  // card strobe toggles once per cycle while host is ready; halts to pause
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) card_data_strobe_o <= 1'b0;
    else if (udma_q == CHC_UDMA_IN && !hrdy_n_s && !stop_s)
      card_data_strobe_o <= !card_data_strobe_o;
  end

  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) hstb_q <= 1'b0;
    else        hstb_q <= hstb_s;
  end
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) host_data_latch_o <= 1'b0;
    else        host_data_latch_o <= (udma_q == CHC_UDMA_OUT) && (hstb_s != hstb_q);
  end

  // ----------------------------------------------------------------
  // wait / ready / dma ready pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      wait_n_o           <= 1'b1;
      card_dma_ready_n_o <= 1'b1;
    end else begin
      card_dma_ready_n_o <= !((udma_q == CHC_UDMA_OUT) && core_can_accept_i);
      if (mode_o == CHC_MODE_IDE) wait_n_o <= init_done && core_word_ok_i;
      else wait_n_o <= !(core_busy_i && init_done);
    end
  end

  // ----------------------------------------------------------------
  // write strobe decode, on trailing edge
  // ----------------------------------------------------------------
  logic we_n_q;
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) we_n_q <= 1'b1;
    else        we_n_q <= we_n_s;
  end
  logic we_rise;
  assign we_rise = we_n_s && !we_n_q && init_done;
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) begin
      common_wr_o <= 1'b0;
      attr_wr_o   <= 1'b0;
    end else begin
      // ide mode drops the strobe entirely
      common_wr_o <= we_rise && (mode_o == CHC_MODE_MEM) && attr_n_s;
      attr_wr_o   <= we_rise && (mode_o != CHC_MODE_IDE) && !attr_n_s;
    end
  end

  // ----------------------------------------------------------------
  // write protect / 16-bit indication pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge rst_q) begin
    if (!rst_q) wp_port_is_wide_n_o <= 1'b1;
    else begin
      unique case (mode_o)
        CHC_MODE_MEM: wp_port_is_wide_n_o <= !init_done;
        CHC_MODE_IO:  wp_port_is_wide_n_o <= !core_wide_port_i;
        CHC_MODE_IDE: wp_port_is_wide_n_o <= !core_word_xfer_i;
        default:      wp_port_is_wide_n_o <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_ack_ignored: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (udma_q == CHC_UDMA_IDLE && !dma_request_o) |=> udma_q == CHC_UDMA_IDLE)
    else $error("burst started without request");
  chk_stop_ends: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (burst && stop_s && !card_in_reset_o && mode_o == CHC_MODE_IDE) |=> !burst && burst_end_o)
    else $error("stop did not end burst");
  chk_soft_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (soft_s && mode_d != CHC_MODE_IDE) |=> card_in_reset_o)
    else $error("soft reset ignored");
  chk_ide_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (!rst_pin_s && mode_d == CHC_MODE_IDE) |=> card_in_reset_o)
    else $error("ide reset ignored");
  chk_stuck_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (!armed_q && !soft_s && mode_d != CHC_MODE_IDE && rcnt_q == '0) |=> !card_in_reset_o)
    else $error("stuck reset held card");
  chk_wp_low: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (mode_o == CHC_MODE_MEM && init_done) ##1 (mode_o == CHC_MODE_MEM) |-> !wp_port_is_wide_n_o)
    else $error("write protect not low");
  chk_ide_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    ($past(mode_o) == CHC_MODE_IDE) |-> !common_wr_o && !attr_wr_o)
    else $error("write in ide mode");
  chk_strobe_pause: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (udma_q != CHC_UDMA_IN || hrdy_n_s) |=> $stable(card_data_strobe_o))
    else $error("strobe moved while paused");
  chk_out_latch: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (udma_q == CHC_UDMA_OUT && hstb_s != hstb_q) |=> host_data_latch_o)
    else $error("host strobe edge missed");
  chk_dma_ready: assert property (@(posedge clk_sys_i) disable iff (!rst_q)
    (udma_q != CHC_UDMA_OUT) |=> card_dma_ready_n_o)
    else $error("dma ready outside write");

  cov_burst_in:  cover property (@(posedge clk_sys_i) udma_q == CHC_UDMA_IN);
  cov_burst_out: cover property (@(posedge clk_sys_i) host_data_latch_o);
  cov_attr_wr:   cover property (@(posedge clk_sys_i) attr_wr_o);
  cov_re_arm:    cover property (@(posedge clk_sys_i) $rose(armed_q));
endmodule // chc_host_ctrl
`default_nettype wire

// *** chc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module chc_host_model (
  input  wire logic clk_sys_i,
  input  wire logic dma_request_i,
  input  wire logic rogue_ack_i,
  input  wire logic out_burst_i,
  output var  logic dma_ack_n_o,
  output var  logic host_data_strobe_o
);
  // acknowledge only answers a pending request, unless told to misbehave
  always @(posedge clk_sys_i) begin
    dma_ack_n_o <= ~(dma_request_i | rogue_ack_i);
  end
  // 125 ns strobe, standing still outside a data-out burst; offset keeps
  // its edges off the bench's input edges
  initial begin
    host_data_strobe_o = 1'b0;
    #3;
    forever begin
      #61;
      if (out_burst_i) host_data_strobe_o = ~host_data_strobe_o;
      #64;
      if (out_burst_i) host_data_strobe_o = ~host_data_strobe_o;
    end
  end
endmodule // chc_host_model
`default_nettype wire

// *** chc_pkg.sv ***
package chc_pkg;
  typedef enum logic [1:0] {
    CHC_MODE_MEM,
    CHC_MODE_IO,
    CHC_MODE_IDE
  } chc_mode_t;
  typedef enum logic [1:0] {
    CHC_UDMA_IDLE,
    CHC_UDMA_IN,
    CHC_UDMA_OUT
  } chc_udma_t;
endpackage

// *** chc_regs.svh ***
`ifndef CHC_REGS_SVH
`define CHC_REGS_SVH
// reset pulse length in system clocks
`define CHC_INIT_RST_CYC   16'h0040
// ready delay after reset release
`define CHC_BUSY_CYC       16'h0020
`define CHC_CNT_W          16
// synchroniser reset values, each pin at its idle level
`define CHC_PIN_IDLE       10'h2F2
`endif

// *** chc_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module chc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    // reset to idle levels: an all-zero start would fake a low reset pin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule // chc_sync
`default_nettype wire
